// ==== dlth_pkg.sv ====
`default_nettype none
package dlth_pkg;
  // ------------------------------------------------------------
  // widths and constants
  // ------------------------------------------------------------
  localparam int unsigned WAKE_W        = 4;     // one of sixteen wakeup times
  localparam int unsigned PATH_N        = 2;     // read-data, write-data
  localparam int unsigned PATH_RD       = 0;     // read-data path index
  localparam int unsigned PATH_WR       = 1;     // write-data path index
  localparam logic [3:0]  WAKE_RST      = 4'h0;  // wakeup select after reset
  localparam int unsigned STROBE_GAP_NS = 40;    // least spacing of level strobes
  localparam int unsigned CLK_NS        = 5;     // 200 MHz clock period
  localparam int unsigned STROBE_GAP_CY =
    (STROBE_GAP_NS + CLK_NS - 1) / CLK_NS;       // rounded up, cycles

  // training sequencer states
  typedef enum logic [2:0] {
    DLTH_IDLE,
    DLTH_RDEYE,
    DLTH_RDGATE,
    DLTH_WRLVL,
    DLTH_WRGAP
  } dlth_train_e;
endpackage
`default_nettype wire

// ==== dlth_lp_path.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// one low-power opportunity request set for a single data path
// ------------------------------------------------------------
module dlth_lp_path
(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        idle_ok,     // path has no work, may sleep
  input  wire logic                        traffic_req, // user wants traffic on path
  input  wire logic [dlth_pkg::WAKE_W-1:0] wake_sel,    // user chosen wakeup time
  input  wire logic                        lp_ack,      // phy acknowledge, synchronous
  output logic                             lp_req,      // request toward phy
  output logic [dlth_pkg::WAKE_W-1:0]      lp_wakeup,   // wakeup select toward phy
  output logic                             lp_acked,    // phy took the opportunity
  output logic                             path_ready   // traffic may be issued
);
  import dlth_pkg::*;
  // request: raised only while idle and no traffic pending
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lp_req <= 1'b0;
    else
      lp_req <= idle_ok && !traffic_req;
  end

  // wakeup select follows user select while request is low, held stable while it is up
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lp_wakeup <= WAKE_RST;
    else if (!lp_req)
      lp_wakeup <= wake_sel;
  end

  // ack is informative only; nothing waits on it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lp_acked <= 1'b0;
    else
      lp_acked <= lp_req && lp_ack;
  end

  // traffic goes only once request is down
  assign path_ready = !lp_req;
endmodule
`default_nettype wire

// ==== dlth_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - write path low-power request when idle
// - read path has independent request set
// - acknowledge optional, never waited on
// - four-bit wakeup select with each request
// - read eye request answered by enable
// - gate request answered by gate enable
// - write request answered by write enable
// - strobe pulsed during write leveling
// - controller-judged response gives sampled dq
module dlth_top
(
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // user side, same clock
  input  wire logic                        rd_idle,
  input  wire logic                        rd_traffic_req,
  input  wire logic [dlth_pkg::WAKE_W-1:0] rd_wake_sel,
  input  wire logic                        wr_idle,
  input  wire logic                        wr_traffic_req,
  input  wire logic [dlth_pkg::WAKE_W-1:0] wr_wake_sel,
  input  wire logic                        controller_judges_training_mode,
  output logic                             rd_ready,
  output logic                             wr_ready,
  output logic                             rd_lp_acked,
  output logic                             wr_lp_acked,
  output logic                             wrlvl_delay_inc,
  output logic                             wrlvl_delay_dec,
  output logic                             training_busy,
  // dfi side
  output logic                             dfi_rdlp_req,
  input  wire logic                        dfi_rdlp_ack,
  output logic [dlth_pkg::WAKE_W-1:0]      dfi_rdlp_wakeup,
  output logic                             dfi_wrlp_req,
  input  wire logic                        dfi_wrlp_ack,
  output logic [dlth_pkg::WAKE_W-1:0]      dfi_wrlp_wakeup,
  input  wire logic                        dfi_rdlvl_req,
  output logic                             dfi_rdlvl_en,
  input  wire logic                        dfi_rdlvl_gate_req,
  output logic                             dfi_rdlvl_gate_en,
  input  wire logic                        dfi_rdlvl_resp,
  input  wire logic                        dfi_wrlvl_req,
  output logic                             dfi_wrlvl_en,
  output logic                             dfi_wrlvl_strobe,
  input  wire logic                        dfi_wrlvl_resp
);
  import dlth_pkg::*;

  // ------------------------------------------------------------
  // low-power path sets
  // ------------------------------------------------------------
  logic [PATH_N-1:0]             lp_idle;       // per path idle
  logic [PATH_N-1:0]             lp_traffic;    // per path traffic request
  logic [PATH_N-1:0][WAKE_W-1:0] lp_wsel;       // per path wake select
  logic [PATH_N-1:0]             lp_ack;        // per path phy ack
  logic [PATH_N-1:0]             lp_req;        // per path request out
  logic [PATH_N-1:0][WAKE_W-1:0] lp_wake;       // per path wakeup out
  logic [PATH_N-1:0]             lp_acked;      // per path ack seen
  logic [PATH_N-1:0]             lp_ready;      // per path traffic allowed

  // training holds both paths awake: phy needs the data paths live
  assign lp_idle[PATH_RD]    = rd_idle && !training_busy;
  assign lp_idle[PATH_WR]    = wr_idle && !training_busy;
  assign lp_traffic[PATH_RD] = rd_traffic_req;
  assign lp_traffic[PATH_WR] = wr_traffic_req;
  assign lp_wsel[PATH_RD]    = rd_wake_sel;
  assign lp_wsel[PATH_WR]    = wr_wake_sel;
  assign lp_ack[PATH_RD]     = dfi_rdlp_ack;
  assign lp_ack[PATH_WR]     = dfi_wrlp_ack;

  // one independent instance per path
  genvar gi;
  generate
    for (gi = 0; gi < PATH_N; gi++)
    begin : g_path
      dlth_lp_path u_path (
        .clk         (clk),
        .resetn      (resetn),
        .idle_ok     (lp_idle[gi]),
        .traffic_req (lp_traffic[gi]),
        .wake_sel    (lp_wsel[gi]),
        .lp_ack      (lp_ack[gi]),
        .lp_req      (lp_req[gi]),
        .lp_wakeup   (lp_wake[gi]),
        .lp_acked    (lp_acked[gi]),
        .path_ready  (lp_ready[gi])
      );
    end
  endgenerate

  assign dfi_rdlp_req    = lp_req[PATH_RD];
  assign dfi_rdlp_wakeup = lp_wake[PATH_RD];
  assign dfi_wrlp_req    = lp_req[PATH_WR];
  assign dfi_wrlp_wakeup = lp_wake[PATH_WR];
  assign rd_lp_acked     = lp_acked[PATH_RD];
  assign wr_lp_acked     = lp_acked[PATH_WR];
  // no traffic while training or while a request is still up
  assign rd_ready        = lp_ready[PATH_RD] && !training_busy;
  assign wr_ready        = lp_ready[PATH_WR] && !training_busy;

  // ------------------------------------------------------------
  // training sequencer
  // ------------------------------------------------------------
  dlth_train_e state_r;       // current training phase
  logic [7:0]  gap_cnt_r;     // spacing between strobes
  logic        strobe_r;      // strobe pulse register
  logic        resp_d_r;      // last write response sample
  logic        wr_leave;      // write leveling run ends at this edge

  // request priority: read eye, then gate, then write leveling
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_r <= DLTH_IDLE;
    else
    begin
      case (state_r)
        DLTH_IDLE:
          if (dfi_rdlvl_req)
            state_r <= DLTH_RDEYE;
          else if (dfi_rdlvl_gate_req)
            state_r <= DLTH_RDGATE;
          else if (dfi_wrlvl_req)
            state_r <= DLTH_WRLVL;
        // enable held until the phy reports done
        DLTH_RDEYE:
          if (dfi_rdlvl_resp)
            state_r <= DLTH_IDLE;
        DLTH_RDGATE:
          if (dfi_rdlvl_resp)
            state_r <= DLTH_IDLE;
        // phy-judged: response means aligned; controller-judged: it is dq
        DLTH_WRLVL:
          if (!controller_judges_training_mode && dfi_wrlvl_resp)
            state_r <= DLTH_IDLE;
          else if (controller_judges_training_mode && !dfi_wrlvl_req)
            state_r <= DLTH_IDLE;
          else if (strobe_r)
            state_r <= DLTH_WRGAP;
        DLTH_WRGAP:
          if (!controller_judges_training_mode && dfi_wrlvl_resp)
            state_r <= DLTH_IDLE;
          else if (controller_judges_training_mode && !dfi_wrlvl_req)
            state_r <= DLTH_IDLE;
          else if (gap_cnt_r == 8'h00)
            state_r <= DLTH_WRLVL;
        default:
          state_r <= DLTH_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // write leveling strobe
  // ------------------------------------------------------------
  // run ends: phy-judged on response, controller-judged on request drop
  assign wr_leave = controller_judges_training_mode ? !dfi_wrlvl_req : dfi_wrlvl_resp;

  // strobe spacing counter, loaded after each pulse
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      gap_cnt_r <= 8'h00;
    else if (strobe_r)
      gap_cnt_r <= 8'(STROBE_GAP_CY - 1);
    // spacing is kept within one run only, so each new run strobes at once
    else if (state_r == DLTH_IDLE)
      gap_cnt_r <= 8'h00;
    else if (gap_cnt_r != 8'h00)
      gap_cnt_r <= gap_cnt_r - 8'h01;
  end

  // one-cycle strobe each time leveling phase is entered
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      strobe_r <= 1'b0;
    else
      strobe_r <= (state_r == DLTH_WRLVL) && !strobe_r && (gap_cnt_r == 8'h00)
                  && !wr_leave;
  end
  assign dfi_wrlvl_strobe = strobe_r;

  // ------------------------------------------------------------
  // controller-judged delay steering
  // ------------------------------------------------------------
  // sample dq response one gap after each strobe, then steer delay
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      resp_d_r        <= 1'b0;
      wrlvl_delay_inc <= 1'b0;
      wrlvl_delay_dec <= 1'b0;
    end
    else
    begin
      resp_d_r <= dfi_wrlvl_resp;
      // dq low: clock not yet seen, push strobe later; high: pull earlier
      wrlvl_delay_inc <= controller_judges_training_mode && (state_r == DLTH_WRGAP)
                         && (gap_cnt_r == 8'h01) && !resp_d_r;
      wrlvl_delay_dec <= controller_judges_training_mode && (state_r == DLTH_WRGAP)
                         && (gap_cnt_r == 8'h01) && resp_d_r;
    end
  end

  // ------------------------------------------------------------
  // training enables
  // ------------------------------------------------------------
  // enables straight from state; phy starts on enable alone
  assign dfi_rdlvl_en      = (state_r == DLTH_RDEYE);
  assign dfi_rdlvl_gate_en = (state_r == DLTH_RDGATE);
  assign dfi_wrlvl_en      = (state_r == DLTH_WRLVL) || (state_r == DLTH_WRGAP);
  assign training_busy     = (state_r != DLTH_IDLE);
endmodule
`default_nettype wire

// ==== dlth_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// dfi sideband checker, sees only the top ports
// ------------------------------------------------------------
module dlth_monitor
(
  input wire logic                        clk,
  input wire logic                        resetn,
  input wire logic                        rd_idle,
  input wire logic                        rd_traffic_req,
  input wire logic                        wr_idle,
  input wire logic                        wr_traffic_req,
  input wire logic                        controller_judges_training_mode,
  input wire logic                        rd_lp_acked,
  input wire logic                        wrlvl_delay_inc,
  input wire logic                        wrlvl_delay_dec,
  input wire logic                        training_busy,
  input wire logic                        dfi_rdlp_req,
  input wire logic                        dfi_rdlp_ack,
  input wire logic                        dfi_wrlp_req,
  input wire logic                        dfi_rdlvl_req,
  input wire logic                        dfi_rdlvl_en,
  input wire logic                        dfi_rdlvl_gate_req,
  input wire logic                        dfi_rdlvl_gate_en,
  input wire logic                        dfi_rdlvl_resp,
  input wire logic                        dfi_wrlvl_req,
  input wire logic                        dfi_wrlvl_en,
  input wire logic                        dfi_wrlvl_strobe,
  input wire logic                        dfi_wrlvl_resp,
  input wire logic [dlth_pkg::WAKE_W-1:0] dfi_wrlp_wakeup
);
  import dlth_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_WR_LP: assert property (wr_idle && !wr_traffic_req && !training_busy |=> dfi_wrlp_req)
    else $error("write path request missing");
  AST_RD_LP: assert property (rd_idle && !rd_traffic_req && !training_busy |=> dfi_rdlp_req)
    else $error("read path request missing");
  AST_ACKED: assert property (dfi_rdlp_req && dfi_rdlp_ack |=> rd_lp_acked)
    else $error("acknowledge not reported");
  AST_WAKE: assert property (dfi_wrlp_req && $past(dfi_wrlp_req) |-> $stable(dfi_wrlp_wakeup))
    else $error("wakeup select moved under request");
  AST_DROP: assert property (wr_traffic_req |=> !dfi_wrlp_req)
    else $error("request kept with traffic");
  AST_EYE: assert property (dfi_rdlvl_req && !training_busy |=> dfi_rdlvl_en)
    else $error("eye request not answered");
  AST_GATE: assert property (dfi_rdlvl_gate_req && !dfi_rdlvl_req && !training_busy |=> dfi_rdlvl_gate_en)
    else $error("gate request not answered");
  AST_WR_EN: assert property (dfi_wrlvl_req && !dfi_rdlvl_req && !dfi_rdlvl_gate_req && !training_busy |=> dfi_wrlvl_en)
    else $error("write request not answered");
  AST_RD_HOLD: assert property (dfi_rdlvl_en && !dfi_rdlvl_resp |=> dfi_rdlvl_en)
    else $error("eye enable dropped early");
  AST_STROBE: assert property ($rose(dfi_wrlvl_en) |=> dfi_wrlvl_strobe)
    else $error("no strobe after enable");
  AST_STROBE_EN: assert property (dfi_wrlvl_strobe |-> dfi_wrlvl_en)
    else $error("strobe outside write leveling");
  AST_ADJ: assert property (dfi_wrlvl_strobe && controller_judges_training_mode ##1 dfi_wrlvl_req [*7] |=> wrlvl_delay_inc != $past(dfi_wrlvl_resp) && wrlvl_delay_dec == $past(dfi_wrlvl_resp))
    else $error("delay step disagrees with dq");
  cover property (rd_lp_acked);
  cover property (wrlvl_delay_inc);
  cover property (wrlvl_delay_dec);
  cover property (dfi_rdlvl_gate_en && dfi_rdlvl_resp);
endmodule
bind dlth_top dlth_monitor dlth_monitor_inst (.*);
`default_nettype wire

// ==== dlth_phy_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// phy side of the sideband, bench steered
// ------------------------------------------------------------
module dlth_phy_model
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ack_on,  // bench allows acknowledges
  input  wire logic       dq,      // level the memory hands back
  input  wire logic       controller_judges_training_mode,
  input  wire logic       dfi_rdlp_req,
  input  wire logic       dfi_wrlp_req,
  input  wire logic       dfi_rdlvl_en,
  input  wire logic       dfi_rdlvl_gate_en,
  input  wire logic       dfi_wrlvl_en,
  input  wire logic       dfi_wrlvl_strobe,
  input  wire logic [2:0] trig,    // eye, gate, write request
  input  wire logic [3:0] dly,     // work cycles before answer
  output logic            dfi_rdlp_ack,
  output logic            dfi_wrlp_ack,
  output logic            dfi_rdlvl_req,
  output logic            dfi_rdlvl_gate_req,
  output logic            dfi_wrlvl_req,
  output logic            dfi_rdlvl_resp,
  output logic            dfi_wrlvl_resp
);
  import dlth_pkg::*;
  logic [3:0] cnt_r, sc_r;  // work count, dq window
  logic [1:0] ns_r;         // strobes seen
  logic       wdone_r;      // phy judged write done
  wire logic rfire = (dfi_rdlvl_en | dfi_rdlvl_gate_en) && cnt_r == dly && !dfi_rdlvl_resp;
  wire logic wfire = dfi_wrlvl_en && !controller_judges_training_mode && cnt_r == dly && !wdone_r;
  wire logic cdone = controller_judges_training_mode && ns_r == 2'd3 && sc_r == 4'h1;
  // acknowledge only when the bench allows, never owed
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) {dfi_rdlp_ack, dfi_wrlp_ack} <= 2'b00;
    else {dfi_rdlp_ack, dfi_wrlp_ack} <= {dfi_rdlp_req, dfi_wrlp_req} & {2{ack_on}};
  // work starts on the enable alone; requests drop with the answer, controller-judged write request after the third strobe's dq window
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      {dfi_rdlvl_req, dfi_rdlvl_gate_req, dfi_wrlvl_req, dfi_rdlvl_resp, wdone_r} <= '0;
      {cnt_r, sc_r, ns_r} <= '0;
    end
    else
    begin
      cnt_r <= (dfi_rdlvl_en | dfi_rdlvl_gate_en | dfi_wrlvl_en) ? cnt_r + 4'h1 : 4'h0;
      dfi_rdlvl_resp <= rfire;
      wdone_r <= wfire;
      dfi_rdlvl_req <= trig[0] | dfi_rdlvl_req & ~(rfire & dfi_rdlvl_en);
      dfi_rdlvl_gate_req <= trig[1] | dfi_rdlvl_gate_req & ~(rfire & dfi_rdlvl_gate_en);
      dfi_wrlvl_req <= trig[2] | dfi_wrlvl_req & ~(wfire | cdone);
      sc_r <= dfi_wrlvl_strobe ? 4'h8 : sc_r - {3'b0, sc_r != 4'h0};
      ns_r <= dfi_wrlvl_en ? ns_r + {1'b0, dfi_wrlvl_strobe} : 2'd0;
    end
  // dq only inside its window, inverted outside so no stale level
  assign dfi_wrlvl_resp = controller_judges_training_mode ? (sc_r != 4'h0 ? dq : ~dq) : wdone_r;
endmodule
`default_nettype wire

// ==== dlth_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// bench: design, phy model, scenarios
// ------------------------------------------------------------
module testbench;
  import dlth_pkg::*;
  logic clk = 0, resetn = 0, rd_idle = 0, rd_traffic_req = 0, wr_idle = 0, ack_on = 0;
  logic wr_traffic_req = 0, controller_judges_training_mode = 0, dq = 0;
  logic [3:0] rd_wake_sel = 0, wr_wake_sel = 0, dly = 0;
  logic [2:0] trig = 0;
  logic rd_ready, wr_ready, rd_lp_acked, wr_lp_acked, wrlvl_delay_inc, wrlvl_delay_dec;
  logic training_busy, dfi_rdlp_req, dfi_rdlp_ack, dfi_wrlp_req, dfi_wrlp_ack;
  logic dfi_rdlvl_req, dfi_rdlvl_en, dfi_rdlvl_gate_req, dfi_rdlvl_gate_en, dfi_rdlvl_resp;
  logic dfi_wrlvl_req, dfi_wrlvl_en, dfi_wrlvl_strobe, dfi_wrlvl_resp;
  logic [3:0] dfi_rdlp_wakeup, dfi_wrlp_wakeup;
  wire logic [2:0] en_v = {dfi_wrlvl_en, dfi_rdlvl_gate_en, dfi_rdlvl_en};
  int err_total = 0, n_tests = 0, cyc = 0;
  dlth_top dlth_top_inst (.*);
  dlth_phy_model dlth_phy_model_inst (.*);
  always #2.5 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, far above the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      summarize;
    end
  end
  // every wakeup code on the write path, read path apart
  task automatic t_lp;
    for (int i = 0; i < 16; i++)
    begin
      wr_wake_sel = 4'(i);
      wr_traffic_req = 1'b0;
      wr_idle = 1'b1;
      tick(2);
      chk(dfi_wrlp_req, 1'b1);
      chk(dfi_wrlp_wakeup, 4'(i));
      chk({wr_lp_acked, wr_ready, dfi_rdlp_req}, 3'b000);
      wr_traffic_req = 1'b1;
      tick(1);
      chk({dfi_wrlp_req, wr_ready}, 2'b01);
    end
    rd_wake_sel = 4'ha;
    ack_on = 1'b1;
    rd_idle = 1'b1;
    wr_traffic_req = 1'b0;
    tick(3);
    chk({rd_lp_acked, wr_lp_acked}, 2'b11);
    chk(dfi_rdlp_wakeup, 4'ha);
    rd_traffic_req = 1'b1;
    tick(1);
    chk({dfi_rdlp_req, rd_ready, dfi_wrlp_req}, 3'b011);
    wr_traffic_req = 1'b1;
    $display("test low power done");
  endtask
  // one training kind, answer delay, judging mode, dq level
  task automatic t_train(input int k, input logic [3:0] d, input logic m, input logic q);
    int n = 0, s = 0, ni = 0, nd = 0;
    dly = d;
    controller_judges_training_mode = m;
    dq = q;
    trig[k] = 1'b1;
    tick(1);
    trig = 3'b000;
    tick(1);
    chk({1'b0, en_v}, 4'h1 << k);
    chk({wr_ready, rd_ready}, 2'b00);
    while (training_busy === 1'b1 && n < 200)
    begin
      tick(1);
      n++;
      s += dfi_wrlvl_strobe;
      ni += wrlvl_delay_inc;
      nd += wrlvl_delay_dec;
    end
    chk({n < 200, en_v}, 4'h8);
    chk({wr_ready, rd_ready}, 2'b11);
    if (k == 2) chk(s != 0, 1'b1);
    chk(4'(m ? (q ? ni : nd) : ni + nd), 4'h0);
    if (m) chk((q ? nd : ni) > 1, 1'b1);
    $display("test training %0d done", k);
  endtask
  initial
  begin
    tick(12);
    resetn = 1'b1;
    tick(2);
    t_lp;
    t_train(0, 4'h3, 1'b0, 1'b0);
    t_train(1, 4'hc, 1'b0, 1'b0);
    t_train(2, 4'h2, 1'b0, 1'b0);
    t_train(2, 4'h0, 1'b1, 1'b0);
    t_train(2, 4'h0, 1'b1, 1'b1);
    summarize;
  end
endmodule
`default_nettype wire
